// [verilog/usbat_device.sv]
// module: device end, configuration words, pull-up control, vbus monitor and endpoint routing
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - max current word in 2mA steps, default 0
// - vbus select 0..15 picks monitor line
// - no vbus select means vbus always present
// - self powered flag mirrors attributes bit 7
// - pull-up select 0..15 line, 16 internal
// - no pull-up select drives no line
// - attach by pulling d+ high, d- low
// - hub sees both low as disconnect
// - host enables port and sends reset
// - answer address zero until address assigned
// - commands on control endpoint, interface 0
// - events on interrupt endpoint, interface 0
// - acl data on bulk endpoints, interface 0
// - voice on isochronous, interface 1
// - one control endpoint pair shared by interfaces
// - isochronous errors never retried
// - selected pull-up line driven high while vbus present or not self powered, else driven low
module usbat_device
  import usbat_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  usbat_link_if.device link,
  // classic wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [13:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // general purpose lines
  input wire logic [USBAT_LINES-1:0] gp_line_in,
  output logic [USBAT_LINES-1:0] gp_line_out,
  output logic [USBAT_LINES-1:0] gp_line_oe_out,
  output logic internal_pullup_out,
  output logic vbus_present_out
);
  ////////////////////////////////////////////////////////////////
  // configuration words
  logic [15:0] max_current_setting; // 2mA units
  logic [15:0] pullup_line_select;
  logic [15:0] vbus_monitor_line_select;
  logic [15:0] descriptor_attributes_word;
  logic [6:0] dev_addr; // current usb address
  logic [USBAT_LINES-1:0] gp_s1; // synchroniser first stage
  logic [USBAT_LINES-1:0] gp_s2; // synchroniser second stage
  logic vbus_now; // selected vbus level
  logic bus_access; // wishbone request present
  logic [11:0] idx; // word index
  logic [15:0] wmask; // byte lane mask
  logic up_in_ready; // upstream fifo has room
  logic dn_valid; // downstream fifo output
  logic [10:0] dn_word;
  logic dn_take;
  logic dn_mine; // packet for this address
  logic [10:0] up_word;
  logic [7:0] cmd_data; // last command byte
  logic cmd_seen;
  function automatic logic is_line(input logic [15:0] sel);
    is_line = (sel <= USBAT_LINE_MAX);
  endfunction
  assign bus_access = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign idx = wb_adr_in[13:2];
  assign wmask = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  ////////////////////////////////////////////////////////////////
  // wishbone write and ack, one wait state
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wb_ack_out <= 1'b0;
      max_current_setting <= USBAT_RST_MAX_CURRENT;
      pullup_line_select <= USBAT_RST_PULLUP_SEL;
      vbus_monitor_line_select <= USBAT_RST_VBUS_SEL;
      descriptor_attributes_word <= USBAT_RST_DESC_ATTR;
    end else begin
      wb_ack_out <= bus_access;
      if (bus_access && wb_we_in) begin
        unique case (idx)
          USBAT_IDX_MAX_CURRENT: begin
            max_current_setting <= (max_current_setting & ~wmask) | (wb_dat_in[15:0] & wmask);
          end
          USBAT_IDX_PULLUP_SEL: begin
            pullup_line_select <= (pullup_line_select & ~wmask) | (wb_dat_in[15:0] & wmask);
          end
          USBAT_IDX_VBUS_SEL: begin
            vbus_monitor_line_select <= (vbus_monitor_line_select & ~wmask)
              | (wb_dat_in[15:0] & wmask);
          end
          USBAT_IDX_DESC_ATTR: begin
            descriptor_attributes_word <= (descriptor_attributes_word & ~wmask)
              | (wb_dat_in[15:0] & wmask);
          end
          USBAT_IDX_SELF_POWERED: begin
            if (wb_sel_in[0]) begin
              descriptor_attributes_word[USBAT_ATTR_SELF_BIT] <= wb_dat_in[0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
  // wishbone read mux, unmapped reads zero
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wb_dat_out <= 32'h0;
    end else if (bus_access && !wb_we_in) begin
      unique case (idx)
        USBAT_IDX_MAX_CURRENT: wb_dat_out <= {16'h0, max_current_setting};
        USBAT_IDX_PULLUP_SEL: wb_dat_out <= {16'h0, pullup_line_select};
        USBAT_IDX_VBUS_SEL: wb_dat_out <= {16'h0, vbus_monitor_line_select};
        USBAT_IDX_DESC_ATTR: wb_dat_out <= {16'h0, descriptor_attributes_word};
        USBAT_IDX_SELF_POWERED: wb_dat_out <= {31'h0,
          descriptor_attributes_word[USBAT_ATTR_SELF_BIT]};
        USBAT_IDX_STATUS: wb_dat_out <= {15'h0, cmd_seen, cmd_data, vbus_now, dev_addr};
        default: wb_dat_out <= 32'h0;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////
  // line synchroniser
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      gp_s1 <= '0;
      gp_s2 <= '0;
    end else begin
      gp_s1 <= gp_line_in;
      gp_s2 <= gp_s1;
    end
  end
  // vbus selection, absent select means always present
  always_comb begin
    if (is_line(vbus_monitor_line_select)) begin
      vbus_now = gp_s2[vbus_monitor_line_select[3:0]];
    end else begin
      vbus_now = 1'b1;
    end
  end
  // pull-up line drive and internal pull-up
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      gp_line_out <= '0;
      gp_line_oe_out <= '0;
      internal_pullup_out <= 1'b0;
      vbus_present_out <= 1'b0;
      link.dp <= 1'b0;
      link.dm <= 1'b0;
    end else begin
      vbus_present_out <= vbus_now;
      gp_line_out <= '0;
      gp_line_oe_out <= '0;
      if (is_line(pullup_line_select)) begin
        gp_line_oe_out[pullup_line_select[3:0]] <= 1'b1;
        gp_line_out[pullup_line_select[3:0]] <= vbus_now
          || !descriptor_attributes_word[USBAT_ATTR_SELF_BIT];
      end
      internal_pullup_out <= (pullup_line_select == USBAT_PULLUP_INTERNAL) && vbus_now;
      link.dp <= vbus_now && (is_line(pullup_line_select)
        || pullup_line_select == USBAT_PULLUP_INTERNAL);
      link.dm <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////
  // address: zero after reset or bus reset, then host assigned
  always_ff @(posedge mclk_in) begin
    if (srst_in || link.bus_reset) begin
      dev_addr <= USBAT_ADDR_DEFAULT;
    end else if (link.addr_valid) begin
      dev_addr <= link.addr;
    end
  end
  // downstream packet buffer
  usbat_fifo #(.WIDTH(11), .DEPTH(USBAT_FIFO_DEPTH)) u_dn (
    .mclk_in(mclk_in), .srst_in(srst_in || link.bus_reset),
    .in_valid_in(link.pkt_valid && link.pkt_addr == dev_addr), .in_ready_out(link.pkt_ready),
    .in_data_in({link.pkt_kind, link.pkt_iface, link.pkt_data}),
    .out_valid_out(dn_valid), .out_ready_in(dn_take), .out_data_out(dn_word));
  assign dn_mine = dn_valid;
  // non-iso traffic stalls on a full upstream buffer, iso goes on and is lost there
  assign dn_take = dn_mine && (dn_word[10:9] == USBAT_EP_ISO || up_in_ready);
  // command capture from shared control endpoint
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cmd_data <= 8'h0;
      cmd_seen <= 1'b0;
    end else if (dn_take && dn_word[10:9] == USBAT_EP_CTRL && dn_word[8] == USBAT_IF_HCI) begin
      cmd_data <= dn_word[7:0];
      cmd_seen <= 1'b1;
    end
  end
  // upstream: commands answer as events on interface 0, bulk and iso loop back
  always_comb begin
    up_word = {USBAT_EP_CTRL, USBAT_IF_HCI, 8'h0};
    unique case (dn_word[10:9])
      USBAT_EP_CTRL: up_word = {USBAT_EP_INTR, USBAT_IF_HCI, dn_word[7:0]};
      USBAT_EP_BULK: up_word = {USBAT_EP_BULK, USBAT_IF_HCI, dn_word[7:0]};
      USBAT_EP_ISO: up_word = {USBAT_EP_ISO, USBAT_IF_VOICE, dn_word[7:0]};
      USBAT_EP_INTR: up_word = {USBAT_EP_INTR, USBAT_IF_HCI, dn_word[7:0]};
    endcase
  end
  // iso bytes are dropped, not retried, when the buffer is full
  usbat_fifo #(.WIDTH(11), .DEPTH(USBAT_FIFO_DEPTH)) u_up (
    .mclk_in(mclk_in), .srst_in(srst_in || link.bus_reset),
    .in_valid_in(dn_take && (dn_word[10:9] != USBAT_EP_CTRL || dn_word[8] == USBAT_IF_HCI)),
    .in_ready_out(up_in_ready), .in_data_in(up_word),
    .out_valid_out(link.up_valid), .out_ready_in(link.up_ready),
    .out_data_out({link.up_kind, link.up_iface, link.up_data}));
endmodule
`default_nettype wire

// [verilog/usbat_pkg.sv]
// package: register map, line select codes and endpoint numbering for the usb attach link
package usbat_pkg;
  // configuration word indices, byte address is four times the index
  localparam logic [11:0] USBAT_IDX_MAX_CURRENT = 12'h2c6;
  localparam logic [11:0] USBAT_IDX_PULLUP_SEL = 12'h2d0;
  localparam logic [11:0] USBAT_IDX_VBUS_SEL = 12'h2d1;
  localparam logic [11:0] USBAT_IDX_SELF_POWERED = 12'h3f2;
  localparam logic [11:0] USBAT_IDX_DESC_ATTR = 12'h25c;
  localparam logic [11:0] USBAT_IDX_STATUS = 12'h100;
  localparam logic [11:0] USBAT_IDX_DATA = 12'h101;
  // reset values
  localparam logic [15:0] USBAT_RST_MAX_CURRENT = 16'h0000;
  localparam logic [15:0] USBAT_RST_PULLUP_SEL = 16'h0010;
  localparam logic [15:0] USBAT_RST_VBUS_SEL = 16'hffff;
  localparam logic [15:0] USBAT_RST_SELF_POWERED = 16'h0001;
  localparam logic [15:0] USBAT_RST_DESC_ATTR = 16'h0080;
  // field positions and magic values
  localparam int USBAT_ATTR_SELF_BIT = 7;
  localparam logic [15:0] USBAT_LINE_MAX = 16'h000f;
  localparam logic [15:0] USBAT_PULLUP_INTERNAL = 16'h0010;
  localparam int USBAT_LINES = 16;
  // endpoint kinds carried on the link
  localparam logic [1:0] USBAT_EP_CTRL = 2'h0;
  localparam logic [1:0] USBAT_EP_INTR = 2'h1;
  localparam logic [1:0] USBAT_EP_BULK = 2'h2;
  localparam logic [1:0] USBAT_EP_ISO = 2'h3;
  localparam logic USBAT_IF_HCI = 1'h0;
  localparam logic USBAT_IF_VOICE = 1'h1;
  localparam logic [6:0] USBAT_ADDR_DEFAULT = 7'h00;
  localparam int USBAT_DATA_W = 8;
  localparam int USBAT_FIFO_DEPTH = 8;
endpackage

// [verilog/usbat_link_if.sv]
// interface: bus lines, reset, address and packet stream between device and hub
`timescale 1ns/10ps
`default_nettype none
interface usbat_link_if;
  logic dp; // d+ level as driven by device pull-up
  logic dm; // d- level
  logic bus_reset; // host usb reset, one cycle
  logic addr_valid; // host assigns address, one cycle
  logic [6:0] addr; // assigned address
  logic pkt_valid; // host to device packet
  logic pkt_ready;
  logic [1:0] pkt_kind; // endpoint kind
  logic pkt_iface; // interface number
  logic [6:0] pkt_addr; // target address
  logic [7:0] pkt_data;
  logic up_valid; // device to host packet
  logic up_ready;
  logic [1:0] up_kind;
  logic up_iface;
  logic [7:0] up_data;
  modport device (output dp, dm, pkt_ready, up_valid, up_kind, up_iface, up_data,
    input bus_reset, addr_valid, addr, pkt_valid, pkt_kind, pkt_iface, pkt_addr, pkt_data,
    up_ready);
  modport host (input dp, dm, pkt_ready, up_valid, up_kind, up_iface, up_data,
    output bus_reset, addr_valid, addr, pkt_valid, pkt_kind, pkt_iface, pkt_addr, pkt_data,
    up_ready);
endinterface
`default_nettype wire

// [verilog/usbat_fifo.sv]
// module: small synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module usbat_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage
  logic [AW-1:0] wr_ptr; // write slot
  logic [AW-1:0] rd_ptr; // read slot
  logic [AW:0] count; // words held
  logic push;
  logic pop;
  assign in_ready_out = (count != (AW+1)'(DEPTH)); // room while fewer than depth words
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  // storage write
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
  // pointers and count
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// [verilog/usbat_host.sv]
// module: hub and host end, attach detect, reset, address assignment and packet issue
`timescale 1ns/10ps
`default_nettype none
module usbat_host
  import usbat_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  usbat_link_if.host link,
  input wire logic [6:0] new_addr_in, // address to assign
  input wire logic tx_valid_in, // packet to send
  output logic tx_ready_out,
  input wire logic [1:0] tx_kind_in,
  input wire logic tx_iface_in,
  input wire logic [7:0] tx_data_in,
  output logic rx_valid_out, // packet received
  output logic [1:0] rx_kind_out,
  output logic rx_iface_out,
  output logic [7:0] rx_data_out,
  output logic attached_out,
  output logic configured_out
);
  typedef enum logic [3:0] {
    USBAT_H_IDLE = 4'h1, USBAT_H_RESET = 4'h2, USBAT_H_ADDR = 4'h4, USBAT_H_RUN = 4'h8
  } usbat_hstate_t;
  usbat_hstate_t state; // enumeration state
  logic dp_s1, dp_s2, dm_s1, dm_s2; // line synchronisers
  logic [6:0] cur_addr; // address in use
  logic connected; // idle j seen
  assign connected = dp_s2 && !dm_s2;
  // line sync
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      {dp_s1, dp_s2, dm_s1, dm_s2} <= 4'h0;
    end else begin
      dp_s1 <= link.dp;
      dp_s2 <= dp_s1;
      dm_s1 <= link.dm;
      dm_s2 <= dm_s1;
    end
  end
  // enumeration: attach, reset, address, run; both low is disconnect
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state <= USBAT_H_IDLE;
      cur_addr <= USBAT_ADDR_DEFAULT;
      link.bus_reset <= 1'b0;
      link.addr_valid <= 1'b0;
      link.addr <= 7'h0;
    end else begin
      link.bus_reset <= 1'b0;
      link.addr_valid <= 1'b0;
      if (!dp_s2 && !dm_s2 && state != USBAT_H_IDLE) begin
        state <= USBAT_H_IDLE;
        cur_addr <= USBAT_ADDR_DEFAULT;
      end else begin
        unique case (state)
          USBAT_H_IDLE: if (connected) begin
            state <= USBAT_H_RESET;
          end
          USBAT_H_RESET: begin
            link.bus_reset <= 1'b1;
            cur_addr <= USBAT_ADDR_DEFAULT;
            state <= USBAT_H_ADDR;
          end
          USBAT_H_ADDR: begin
            link.addr_valid <= 1'b1;
            link.addr <= new_addr_in;
            cur_addr <= new_addr_in;
            state <= USBAT_H_RUN;
          end
          USBAT_H_RUN: begin
          end
        endcase
      end
    end
  end
  // outputs and packet pass-through
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      attached_out <= 1'b0;
      configured_out <= 1'b0;
      rx_valid_out <= 1'b0;
      rx_kind_out <= 2'h0;
      rx_iface_out <= 1'b0;
      rx_data_out <= 8'h0;
    end else begin
      attached_out <= (state != USBAT_H_IDLE);
      configured_out <= (state == USBAT_H_RUN);
      rx_valid_out <= link.up_valid;
      rx_kind_out <= link.up_kind;
      rx_iface_out <= link.up_iface;
      rx_data_out <= link.up_data;
    end
  end
  assign link.up_ready = 1'b1;
  assign link.pkt_valid = tx_valid_in && (state == USBAT_H_RUN);
  assign link.pkt_kind = tx_kind_in;
  assign link.pkt_iface = tx_iface_in;
  assign link.pkt_addr = cur_addr;
  assign link.pkt_data = tx_data_in;
  assign tx_ready_out = link.pkt_ready && (state == USBAT_H_RUN);
endmodule
`default_nettype wire

// [verification/usbat_link_sva.sv]
// checker: link level assertions between the device and host ends
`timescale 1ns/10ps
`default_nettype none
module usbat_link_sva
  import usbat_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic dp,
  input wire logic dm,
  input wire logic bus_reset,
  input wire logic addr_valid,
  input wire logic pkt_valid,
  input wire logic pkt_ready,
  input wire logic [1:0] pkt_kind,
  input wire logic up_valid,
  input wire logic [1:0] up_kind,
  input wire logic up_iface
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  // downstream packet taken by the device
  logic pkt_take;
  assign pkt_take = pkt_valid && pkt_ready;
  ////////////////////////////////////////////////////////////////////////////
  // bus idle level and enumeration order
  idle_state_a: assert property (dp |-> !dm)
    else $error("d- high while d+ is pulled up");
  reset_pulse_a: assert property (bus_reset |=> !bus_reset)
    else $error("bus reset longer than one cycle");
  reset_after_attach_a: assert property ($rose(dp) |-> ##[1:20] bus_reset)
    else $error("no bus reset after attach");
  addr_after_reset_a: assert property (bus_reset |-> ##[1:20] addr_valid)
    else $error("no address assigned after bus reset");
  ////////////////////////////////////////////////////////////////////////////
  // endpoint and interface mapping of upstream traffic
  intr_iface_a: assert property (up_valid && up_kind == USBAT_EP_INTR
    |-> up_iface == USBAT_IF_HCI)
    else $error("interrupt traffic not on interface 0");
  bulk_iface_a: assert property (up_valid && up_kind == USBAT_EP_BULK
    |-> up_iface == USBAT_IF_HCI)
    else $error("bulk traffic not on interface 0");
  iso_iface_a: assert property (up_valid && up_kind == USBAT_EP_ISO
    |-> up_iface == USBAT_IF_VOICE)
    else $error("isochronous traffic not on interface 1");
  no_ctrl_up_a: assert property (up_valid |-> up_kind != USBAT_EP_CTRL)
    else $error("upstream packet on control endpoint");
  ctrl_reply_a: assert property (pkt_take && pkt_kind == USBAT_EP_CTRL
    |-> ##[1:16] (up_valid && up_kind == USBAT_EP_INTR))
    else $error("command not answered by an event");
  iso_reply_a: assert property (pkt_take && pkt_kind == USBAT_EP_ISO
    |-> ##[1:16] (up_valid && up_kind == USBAT_EP_ISO))
    else $error("voice data not returned on isochronous endpoint");
endmodule
`default_nettype wire

// [verification/tb_usb_attach_and_hci_endpoint_map.sv]
// testbench: device and host ends joined over the link, driven by wishbone and packets
`timescale 1ns/10ps
`default_nettype none
module tb_usb_attach_and_hci_endpoint_map
  import usbat_pkg::*;
;
  logic mclk_in, srst_in;
  logic wb_cyc, wb_stb, wb_we, wb_ack;
  logic [13:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, rd;
  logic [15:0] gp_in, gp_out, gp_oe;
  logic int_pu, vbus_pres, attached, configured;
  logic [6:0] new_addr;
  logic tx_valid, tx_ready, tx_iface, rx_valid, rx_iface;
  logic [1:0] tx_kind, rx_kind;
  logic [7:0] tx_data, rx_data;
  int error_cnt = 0;
  int compares = 0;
  ////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  usbat_link_if usbat_link_if_inst ();
  usbat_device usbat_device_inst (.mclk_in(mclk_in), .srst_in(srst_in),
    .link(usbat_link_if_inst), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
    .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat_w), .wb_dat_out(wb_dat_r),
    .wb_ack_out(wb_ack), .gp_line_in(gp_in), .gp_line_out(gp_out), .gp_line_oe_out(gp_oe),
    .internal_pullup_out(int_pu), .vbus_present_out(vbus_pres));
  usbat_host usbat_host_inst (.mclk_in(mclk_in), .srst_in(srst_in),
    .link(usbat_link_if_inst), .new_addr_in(new_addr), .tx_valid_in(tx_valid),
    .tx_ready_out(tx_ready), .tx_kind_in(tx_kind), .tx_iface_in(tx_iface),
    .tx_data_in(tx_data), .rx_valid_out(rx_valid), .rx_kind_out(rx_kind),
    .rx_iface_out(rx_iface), .rx_data_out(rx_data), .attached_out(attached),
    .configured_out(configured));
  usbat_link_sva usbat_link_sva_inst (.mclk_in(mclk_in), .srst_in(srst_in),
    .dp(usbat_link_if_inst.dp), .dm(usbat_link_if_inst.dm),
    .bus_reset(usbat_link_if_inst.bus_reset), .addr_valid(usbat_link_if_inst.addr_valid),
    .pkt_valid(usbat_link_if_inst.pkt_valid), .pkt_ready(usbat_link_if_inst.pkt_ready),
    .pkt_kind(usbat_link_if_inst.pkt_kind), .up_valid(usbat_link_if_inst.up_valid),
    .up_kind(usbat_link_if_inst.up_kind), .up_iface(usbat_link_if_inst.up_iface));
  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one compare for every result, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // classic wishbone single cycle, held until ack is seen at a rising edge
  task automatic wb_xfer(input logic we, input logic [11:0] idx, input logic [15:0] d,
      input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge mclk_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_sel <= sel;
    wb_dat_w <= {16'h0, d};
    // ack and read data are taken at the rising edge that samples ack high
    do begin
      @(posedge mclk_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [15:0] d);
    wb_xfer(1'b1, idx, d, 4'h3);
  endtask
  task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
    wb_xfer(1'b0, idx, 16'h0, 4'hf);
    chk(rd, exp);
  endtask
  // host sends one packet and waits for the device's answer
  task automatic send(input logic [1:0] k, input logic i, input logic [7:0] d,
      input logic [1:0] ek, input logic ei);
    int n;
    n = 0;
    @(posedge mclk_in);
    tx_valid <= 1'b1;
    tx_kind <= k;
    tx_iface <= i;
    tx_data <= d;
    // held until ready is sampled high at a rising edge, released there
    do begin
      @(posedge mclk_in);
      n++;
    end while (tx_ready !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    tx_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk_in);
      n++;
    end while (rx_valid !== 1'b1 && n < 50);
    chk({20'h0, rx_valid, rx_kind, rx_iface, rx_data}, {20'h0, 1'b1, ek, ei, d});
  endtask
  // wait for the host to finish enumeration
  task automatic wait_cfg();
    int n;
    n = 0;
    do begin
      @(negedge mclk_in);
      n++;
    end while (configured !== 1'b1 && n < 400);
    chk({31'h0, configured}, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the expected run of some hundred cycles
  initial begin
    repeat (20000) @(posedge mclk_in);
    error_cnt++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int n;
    srst_in = 1'b1;
    {wb_cyc, wb_stb, wb_we} = 3'h0;
    wb_adr = 14'h0;
    wb_sel = 4'h0;
    wb_dat_w = 32'h0;
    gp_in = 16'h0;
    new_addr = 7'h2a;
    {tx_valid, tx_iface, tx_kind, tx_data} = 12'h0;
    repeat (12) @(posedge mclk_in);
    srst_in <= 1'b0;
    // reset values and an unmapped place
    rdchk(USBAT_IDX_MAX_CURRENT, 32'h0);
    rdchk(USBAT_IDX_PULLUP_SEL, 32'h10);
    rdchk(USBAT_IDX_VBUS_SEL, {16'h0, USBAT_RST_VBUS_SEL});
    rdchk(USBAT_IDX_SELF_POWERED, 32'h1);
    rdchk(USBAT_IDX_DESC_ATTR, 32'h80);
    rdchk(12'h123, 32'h0);
    // attach with internal pull-up and vbus taken as present
    wait_cfg();
    chk({30'h0, usbat_link_if_inst.dp, usbat_link_if_inst.dm}, 32'h2);
    chk({30'h0, vbus_pres, int_pu}, 32'h3);
    chk({16'h0, gp_oe}, 32'h0);
    rdchk(USBAT_IDX_STATUS, 32'haa);
    // traffic on control, bulk and isochronous endpoints, bulk back to back
    send(USBAT_EP_CTRL, USBAT_IF_HCI, 8'h5c, USBAT_EP_INTR, USBAT_IF_HCI);
    send(USBAT_EP_BULK, USBAT_IF_HCI, 8'ha7, USBAT_EP_BULK, USBAT_IF_HCI);
    send(USBAT_EP_BULK, USBAT_IF_HCI, 8'h58, USBAT_EP_BULK, USBAT_IF_HCI);
    send(USBAT_EP_ISO, USBAT_IF_VOICE, 8'h3e, USBAT_EP_ISO, USBAT_IF_VOICE);
    rdchk(USBAT_IDX_STATUS, 32'h15caa);
    // self powered flag mirrors attribute bit 7 both ways
    wr(USBAT_IDX_SELF_POWERED, 16'h0);
    rdchk(USBAT_IDX_DESC_ATTR, 32'h0);
    wr(USBAT_IDX_DESC_ATTR, 16'h0080);
    rdchk(USBAT_IDX_SELF_POWERED, 32'h1);
    // current word, then a write with no byte lanes
    wr(USBAT_IDX_MAX_CURRENT, 16'h0032);
    rdchk(USBAT_IDX_MAX_CURRENT, 32'h32);
    wb_xfer(1'b1, USBAT_IDX_MAX_CURRENT, 16'hffff, 4'h0);
    rdchk(USBAT_IDX_MAX_CURRENT, 32'h32);
    wr(12'h123, 16'hbeef);
    rdchk(12'h123, 32'h0);
    // monitor on line 3, pull-up on line 5, vbus absent first
    wr(USBAT_IDX_VBUS_SEL, 16'h3);
    wr(USBAT_IDX_PULLUP_SEL, 16'h5);
    n = 0;
    do begin
      @(negedge mclk_in);
      n++;
    end while (attached !== 1'b0 && n < 100);
    chk({31'h0, attached}, 32'h0);
    chk({29'h0, vbus_pres, int_pu, gp_out[5]}, 32'h0);
    @(posedge mclk_in);
    gp_in <= 16'h0008;
    wait_cfg();
    chk({16'h0, gp_oe}, 32'h20);
    chk({30'h0, gp_out[5], vbus_pres}, 32'h3);
    // no pull-up selection leaves every line undriven
    wr(USBAT_IDX_PULLUP_SEL, 16'h11);
    n = 0;
    do begin
      @(negedge mclk_in);
      n++;
    end while (gp_oe !== 16'h0 && n < 20);
    chk({16'h0, gp_oe}, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
